/* hw/oka_keepalive_gen.sv */
// Summary of operation
// RQ1: Keep-alive frames only while a K-line session is connected.
// RQ2: Ordinary bus traffic counts as activity and defers keep-alives.
// RQ3: Default idle interval 3 s, host command may change it.
// RQ4: Default ISO 9141 body is 68 6A F1 01 00.
// RQ5: Default ISO 14230 body is C1 33 F1 3E.
// RQ6: Host-defined content replaces default, header bytes first.
// RQ7: Device appends a computed checksum byte; host never supplies it.
// RQ8: Custom content is one to six bytes, checksum excluded.
// RQ9: Host supplies whole frame on every content change.
// RQ10: No keep-alive frames on CAN protocols.
// RQ11: Transmit indicator pulses for each keep-alive frame sent.
// RQ12: Selections 3, 4 and 5 are the K-line protocols.
// RQ13: Idle timer restarts on every frame sent or received.
module oka_keepalive_gen
	import oka_pkg::*;
#(
	parameter int CYC_PER_MS = OKA_CYC_PER_MS,
	parameter logic [15:0] IDLE_MS_DEF = OKA_IDLE_MS_RST,
	parameter logic [7:0] LED_CYC = 8'hFF
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] protocol_i,
	input wire logic connected_i,
	input wire logic bus_activity_i,
	input wire logic set_keepalive_interval_i,
	input wire logic [15:0] interval_ms_i,
	input wire logic define_keepalive_content_i,
	input wire logic [47:0] content_i,
	input wire logic [2:0] content_len_i,
	input wire logic tx_ready_i,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	output logic tx_last_o,
	output logic busy_o,
	output logic tx_led_o
);
	typedef enum {ST_IDLE, ST_SEND, ST_CHK} oka_state_type;

	oka_state_type state_r, state_nxt;
	logic [15:0] idle_ms_r, idle_ms_nxt;
	logic [15:0] quiet_r, quiet_nxt;
	oka_frame_type cust_r, cust_nxt;
	logic cust_ok_r, cust_ok_nxt;
	oka_frame_type cur_r, cur_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic [7:0] sum_r, sum_nxt;
	logic [7:0] led_r, led_nxt;
	oka_byte_type out_r, out_nxt;
	logic last_r, last_nxt;
	logic ms_tick;
	logic kline;
	logic expired;
	oka_frame_type pick;

	// ==========================================================
	// Millisecond timebase
	oka_ms_tick #(
		.CYC_PER_MS(CYC_PER_MS)
	) u_tick (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.clear_i(bus_activity_i),
		.tick_o(ms_tick)
	);

	// ==========================================================
	// Frame selection
	always_comb begin
		kline = (protocol_i == OKA_PROT_9141) || (protocol_i == OKA_PROT_KWP_SLOW)
			|| (protocol_i == OKA_PROT_KWP_FAST); // [RQ12] [RQ10]
		expired = (quiet_r >= idle_ms_r);
		if (cust_ok_r) begin
			pick = cust_r; // [RQ6]
		end else if (protocol_i == OKA_PROT_9141) begin
			pick = '{body: OKA_BODY_9141, len: OKA_LEN_9141}; // [RQ4]
		end else begin
			pick = '{body: OKA_BODY_KWP, len: OKA_LEN_KWP}; // [RQ5]
		end
	end

	// ==========================================================
	// Control and transmit
	always_comb begin
		state_nxt = state_r;
		idle_ms_nxt = idle_ms_r;
		quiet_nxt = quiet_r;
		cust_nxt = cust_r;
		cust_ok_nxt = cust_ok_r;
		cur_nxt = cur_r;
		idx_nxt = idx_r;
		sum_nxt = sum_r;
		out_nxt = out_r;
		last_nxt = last_r;
		led_nxt = (led_r != 8'h00) ? led_r - 8'h01 : 8'h00;
		if (set_keepalive_interval_i) begin
			idle_ms_nxt = interval_ms_i; // [RQ3]
		end
		if (define_keepalive_content_i && content_len_i >= OKA_LEN_MIN
			&& content_len_i <= OKA_LEN_MAX) begin
			cust_nxt = '{body: content_i, len: content_len_i}; // [RQ8] [RQ9]
			cust_ok_nxt = 1'b1;
		end
		if (bus_activity_i || !connected_i || !kline) begin
			quiet_nxt = 16'h0000; // [RQ2] [RQ13]
		end else if (ms_tick && !expired) begin
			quiet_nxt = quiet_r + 16'h0001;
		end
		if (out_r.valid && tx_ready_i) begin
			out_nxt.valid = 1'b0;
			last_nxt = 1'b0;
		end
		case (state_r)
			ST_IDLE: begin
				if (connected_i && kline && expired && !bus_activity_i) begin // [RQ1]
					cur_nxt = pick;
					idx_nxt = 3'h0;
					sum_nxt = OKA_CHK_INIT;
					quiet_nxt = 16'h0000; // [RQ13]
					led_nxt = LED_CYC; // [RQ11]
					state_nxt = ST_SEND;
				end
			end
			ST_SEND: begin
				if (!out_r.valid || tx_ready_i) begin
					out_nxt.valid = 1'b1;
					out_nxt.data = cur_r.body[idx_r * 8 +: 8];
					last_nxt = 1'b0;
					sum_nxt = sum_r + cur_r.body[idx_r * 8 +: 8];
					idx_nxt = idx_r + 3'h1;
					if (idx_r + 3'h1 == cur_r.len) begin
						state_nxt = ST_CHK;
					end
				end
			end
			ST_CHK: begin
				if (!out_r.valid || tx_ready_i) begin
					out_nxt.valid = 1'b1;
					out_nxt.data = sum_r; // [RQ7]
					last_nxt = 1'b1;
					quiet_nxt = 16'h0000;
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r <= ST_IDLE;
			idle_ms_r <= IDLE_MS_DEF;
			quiet_r <= 16'h0000;
			cust_r <= '0;
			cust_ok_r <= 1'b0;
			cur_r <= '0;
			idx_r <= 3'h0;
			sum_r <= OKA_CHK_INIT;
			out_r <= '0;
			last_r <= 1'b0;
			led_r <= 8'h00;
			busy_o <= 1'b0;
			tx_led_o <= 1'b0;
		end else begin
			state_r <= state_nxt;
			idle_ms_r <= idle_ms_nxt;
			quiet_r <= quiet_nxt;
			cust_r <= cust_nxt;
			cust_ok_r <= cust_ok_nxt;
			cur_r <= cur_nxt;
			idx_r <= idx_nxt;
			sum_r <= sum_nxt;
			out_r <= out_nxt;
			last_r <= last_nxt;
			led_r <= led_nxt;
			busy_o <= (state_nxt != ST_IDLE) || out_nxt.valid;
			tx_led_o <= (led_nxt != 8'h00);
		end
	end

	assign tx_valid_o = out_r.valid;
	assign tx_data_o = out_r.data;
	// Last flag drops with the handshake, so it stands only with the checksum
	assign tx_last_o = last_r;

	// ==========================================================
	// Checks
	chk_no_can_tx: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ10]
		$rose(busy_o) |-> $past(kline) && $past(connected_i))
		else $error("keep-alive started outside a K-line session");
	chk_start_expiry: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ3]
		(state_r == ST_IDLE && state_nxt == ST_SEND) |-> quiet_r >= idle_ms_r)
		else $error("keep-alive started before idle interval");
	chk_activity_reset: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ2]
		bus_activity_i |=> quiet_r == 16'h0000)
		else $error("idle timer not cleared by activity");
	chk_frame_restart: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ13]
		(state_r == ST_IDLE && state_nxt == ST_SEND) |=> quiet_r == 16'h0000)
		else $error("idle timer not cleared by keep-alive");
	chk_led_pulse: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ11]
		(state_r == ST_IDLE && state_nxt == ST_SEND) |=> tx_led_o)
		else $error("transmit indicator did not pulse");
	chk_len_range: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ8]
		cust_ok_r |-> cust_r.len >= OKA_LEN_MIN && cust_r.len <= OKA_LEN_MAX)
		else $error("custom length out of range");
	chk_checksum_last: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ7]
		(state_r == ST_CHK && (!out_r.valid || tx_ready_i)) |=> tx_last_o && tx_data_o == $past(sum_r))
		else $error("checksum byte wrong");
	chk_default_9141: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ4]
		(state_r == ST_IDLE && state_nxt == ST_SEND && !cust_ok_r
			&& protocol_i == OKA_PROT_9141) |=> cur_r.len == OKA_LEN_9141)
		else $error("wrong default 9141 length");
	chk_default_kwp: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ5]
		(state_r == ST_IDLE && state_nxt == ST_SEND && !cust_ok_r
			&& protocol_i != OKA_PROT_9141) |=> cur_r.len == OKA_LEN_KWP)
		else $error("wrong default KWP length");
	chk_custom_used: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ6]
		(state_r == ST_IDLE && state_nxt == ST_SEND && cust_ok_r) |=> cur_r == $past(cust_r))
		else $error("custom content not used");
	cov_frame_sent: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) tx_last_o);
	cov_custom: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		cust_ok_r && state_r == ST_SEND);
	cov_stall: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		tx_valid_o && !tx_ready_i);
endmodule

/* hw/oka_ms_tick.sv */
module oka_ms_tick
	import oka_pkg::*;
#(
	parameter int CYC_PER_MS = OKA_CYC_PER_MS
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic clear_i,
	output logic tick_o
);
	logic [23:0] cnt_r;
	logic [23:0] cnt_nxt;
	logic tick_nxt;

	always_comb begin
		cnt_nxt = cnt_r + 24'h000001;
		tick_nxt = 1'b0;
		if (clear_i) begin
			cnt_nxt = 24'h000000;
		end else if (cnt_r == 24'(CYC_PER_MS - 1)) begin
			cnt_nxt = 24'h000000;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_r <= 24'h000000;
			tick_o <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_o <= tick_nxt;
		end
	end
endmodule

/* inc/oka_pkg.sv */
package oka_pkg;
	// Protocol selections
	localparam logic [3:0] OKA_PROT_9141 = 4'h3;
	localparam logic [3:0] OKA_PROT_KWP_SLOW = 4'h4;
	localparam logic [3:0] OKA_PROT_KWP_FAST = 4'h5;
	// Frame limits
	localparam int OKA_MAX_BYTES = 6;
	localparam logic [2:0] OKA_LEN_MIN = 3'h1;
	localparam logic [2:0] OKA_LEN_MAX = 3'h6;
	localparam logic [2:0] OKA_LEN_9141 = 3'h5;
	localparam logic [2:0] OKA_LEN_KWP = 3'h4;
	// Default frame bodies, byte 0 in low bits
	localparam logic [47:0] OKA_BODY_9141 = 48'h0000_01F1_6A68;
	localparam logic [47:0] OKA_BODY_KWP = 48'h0000_3EF1_33C1;
	// Timing
	localparam int OKA_CLK_HZ = 20_000_000;
	localparam int OKA_IDLE_MS_DEF = 3000;
	localparam int OKA_CYC_PER_MS = OKA_CLK_HZ / 1000;
	localparam logic [15:0] OKA_IDLE_MS_RST = 16'h0BB8;
	localparam logic [7:0] OKA_CHK_INIT = 8'h00;

	typedef struct packed {
		logic [7:0] data;
		logic valid;
	} oka_byte_type;

	typedef struct packed {
		logic [47:0] body;
		logic [2:0] len;
	} oka_frame_type;
endpackage

/* verification/oka_ecu_model.sv */
module oka_ecu_model (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic slow_i,
	output logic tx_ready_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt_r;
	// ==========================
	// Byte sink, slow mode takes one byte in three
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_r <= 2'h0;
		end else begin
			cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
		end
	end
	assign tx_ready_o = !slow_i || (cnt_r == 2'h2);
endmodule

/* verification/oka_keepalive_gen_test.sv */
module oka_keepalive_gen_test import oka_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, conn = 1'b0, act = 1'b0, set_i = 1'b0, def = 1'b0;
	logic slow = 1'b0, rdy, val, last, busy, led;
	logic [3:0] prot = 4'h0;
	logic [15:0] ms = 16'h0000;
	logic [47:0] cont = 48'h0;
	logic [2:0] clen = 3'h0;
	logic [7:0] dat;
	int num_errors = 0, num_checks = 0;
	always #25 ref_clk_i = ~ref_clk_i;
	oka_keepalive_gen #(.CYC_PER_MS(4), .IDLE_MS_DEF(16'h0005), .LED_CYC(8'h04))
		oka_keepalive_gen_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .protocol_i(prot),
		.connected_i(conn), .bus_activity_i(act), .set_keepalive_interval_i(set_i),
		.interval_ms_i(ms), .define_keepalive_content_i(def), .content_i(cont),
		.content_len_i(clen), .tx_ready_i(rdy), .tx_valid_o(val), .tx_data_o(dat),
		.tx_last_o(last), .busy_o(busy), .tx_led_o(led));
	oka_ecu_model oka_ecu_model_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.slow_i(slow), .tx_ready_o(rdy));
	// ==========================
	// Helpers
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task cmd(input logic s, input logic [15:0] m, input logic [47:0] c, input logic [2:0] l);
		@(posedge ref_clk_i);
		set_i <= s;
		def <= ~s;
		ms <= m;
		cont <= c;
		clen <= l;
		@(posedge ref_clk_i);
		set_i <= 1'b0;
		def <= 1'b0;
	endtask
	task no_frame(input int n);
		repeat (n) begin
			@(negedge ref_clk_i);
			chk(val, 1'b0);
			chk(busy, 1'b0);
			chk(led, 1'b0);
		end
		@(posedge ref_clk_i);
	endtask
	task get_frame(input logic [7:0] q[$]);
		logic [7:0] sum;
		int n;
		int w;
		logic led_seen;
		sum = 8'h00;
		n = 0;
		w = 0;
		led_seen = 1'b0;
		foreach (q[i]) sum = sum + q[i];
		q.push_back(sum);
		while (n < q.size() && w < 400) begin
			@(negedge ref_clk_i);
			w++;
			led_seen = led_seen | (led === 1'b1);
			if (val === 1'b1 && rdy === 1'b1) begin
				chk(dat, q[n]);
				chk(last, n == q.size() - 1);
				chk(busy, 1'b1);
				n++;
			end
		end
		chk(n, q.size());
		chk(led_seen, 1'b1);
		// Return on the edge that takes the checksum
		@(posedge ref_clk_i);
	endtask
	// ==========================
	// Scenarios
	task t_off;
		prot <= 4'h3;
		no_frame(40);
		conn <= 1'b1;
		for (int p = 0; p < 16; p++) begin
			if (p < 3 || p > 5) begin
				prot <= p[3:0];
				no_frame(30);
			end
		end
	endtask
	task t_defaults;
		prot <= 4'h3;
		get_frame('{8'h68, 8'h6A, 8'hF1, 8'h01, 8'h00});
		slow <= 1'b1;
		prot <= 4'h4;
		get_frame('{8'hC1, 8'h33, 8'hF1, 8'h3E});
		prot <= 4'h5;
		get_frame('{8'hC1, 8'h33, 8'hF1, 8'h3E});
		slow <= 1'b0;
	endtask
	task t_activity;
		prot <= 4'h3;
		get_frame('{8'h68, 8'h6A, 8'hF1, 8'h01, 8'h00});
		repeat (15) begin
			@(posedge ref_clk_i);
			act <= 1'b1;
			@(posedge ref_clk_i);
			act <= 1'b0;
			no_frame(8);
		end
		get_frame('{8'h68, 8'h6A, 8'hF1, 8'h01, 8'h00});
	endtask
	task t_interval;
		int c;
		c = 0;
		cmd(1'b1, 16'h0002, 48'h0, 3'h0);
		get_frame('{8'h68, 8'h6A, 8'hF1, 8'h01, 8'h00});
		while (led !== 1'b1 && c < 100) begin
			@(negedge ref_clk_i);
			c++;
		end
		chk(c >= 6 && c <= 16, 1'b1);
		// Drain the frame just started so the next scenario begins clean
		get_frame('{8'h68, 8'h6A, 8'hF1, 8'h01, 8'h00});
	endtask
	task t_custom;
		cmd(1'b0, 16'h0002, 48'h6655_4433_2211, 3'h6);
		get_frame('{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66});
		prot <= 4'h4;
		cmd(1'b0, 16'h0002, 48'h0000_0000_00A5, 3'h1);
		get_frame('{8'hA5});
		cmd(1'b0, 16'h0002, 48'h7777_7777_7777, 3'h7);
		cmd(1'b0, 16'h0002, 48'h7777_7777_7777, 3'h0);
		get_frame('{8'hA5});
	endtask
	initial begin
		repeat (16) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		t_off();
		t_defaults();
		t_activity();
		t_interval();
		t_custom();
		stop_test();
	end
	initial begin
		#(20000 * 50);
		num_errors++;
		stop_test();
	end
endmodule
